// [lhb_cfg.svh]
// constants for the lcd host bus interface
`ifndef LHB_CFG_SVH
`define LHB_CFG_SVH
`define LHB_DATA_W 8
`define LHB_SER_BITS 4'h8
`define LHB_SER_SI_BIT 7
`define LHB_SER_SCL_BIT 6
`define LHB_BUF_DEPTH 2
`endif

// [lhb_pkg.sv]
// types for the lcd host bus interface
package lhb_pkg;
  typedef enum logic [1:0] {
    LHB_MODE_SEP = 2'b00,
    LHB_MODE_ENA = 2'b01,
    LHB_MODE_SER = 2'b11
  } lhb_mode_type;
endpackage

// [lhb_host_bus.sv]
// host bus front end: parallel and serial capture, read drive, buffer
`timescale 1ns/10ps
`default_nettype none
`include "lhb_cfg.svh"
// What this block does
// - strobes act only while chip select low
// - reset pin low holds reset state
// - command select high data, low instruction
// - separate strobes: capture at write rising edge
// - separate strobes: drive data while read low
// - direction high reads, low writes
// - enable high drives read; falling edge writes
// - parallel bus bidirectional, driven only reading
// - serial data from top bus pin
// - serial clock on second top pin
// - bus style high enable, low strobes
// - parallel select high parallel, low serial
// - serial mode is write only
module lhb_host_bus #(
  parameter int DATA_W = `LHB_DATA_W // byte width
) (
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_sys_rst, // sync reset, high
  input wire logic i_chip_select_n, // chip select, low
  input wire logic i_module_reset_n, // module reset pin, low
  input wire logic i_data_command_select, // 1 data, 0 command
  input wire logic i_bus_style_select, // 1 enable style
  input wire logic i_par_ser_select, // 1 parallel, 0 serial
  input wire logic i_wr_n_rw, // write strobe or direction
  input wire logic i_rd_n_en, // read strobe or enable
  input wire logic [DATA_W-1:0] i_db, // data bus pin levels in
  output logic [DATA_W-1:0] o_db, // data bus drive value
  output logic o_db_oe_n, // data bus enable, low drives
  output logic o_mode_ser, // serial mode active
  output logic o_rx_valid, // received byte valid
  input wire logic i_rx_ready, // consumer accepts byte
  output logic [DATA_W-1:0] o_rx_data, // received byte
  output logic o_rx_is_data, // byte is display data
  input wire logic [DATA_W-1:0] i_rd_data, // byte to read out
  output logic o_rd_pulse, // one pulse per read end
  output logic o_in_ready // buffer can take a byte
);
  import lhb_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // mode and reset
  lhb_mode_type mode; // decoded interface style
  logic rst; // combined reset
  logic sel; // chip selected
  always_comb begin
    rst = i_sys_rst | ~i_module_reset_n;
    sel = ~i_chip_select_n;
    if (!i_par_ser_select) begin
      mode = LHB_MODE_SER;
    end else if (i_bus_style_select) begin
      mode = LHB_MODE_ENA;
    end else begin
      mode = LHB_MODE_SEP;
    end
  end
  assign o_mode_ser = (mode == LHB_MODE_SER);
  ////////////////////////////////////////////////////////////////////////////
  // strobe history, for edge detection against the previous sample
  logic wr_q, wr_d; // previous write pin
  logic rd_q, rd_d; // previous read/enable pin
  logic scl_q, scl_d; // previous serial clock pin
  logic [3:0] cnt_q, cnt_d; // serial bit count
  logic [DATA_W-1:0] sh_q, sh_d; // serial shifter
  logic push; // a byte is complete
  logic [DATA_W-1:0] push_data; // byte to store
  logic push_dc; // its command select
  logic rd_act; // a read is in progress
  logic [DATA_W-1:0] db_q, db_d; // read drive register
  logic rde_q, rde_d; // read drive enable
  logic rdp_q, rdp_d; // read end pulse
  always_comb begin
    wr_d = i_wr_n_rw;
    rd_d = i_rd_n_en;
    scl_d = i_db[`LHB_SER_SCL_BIT];
    cnt_d = cnt_q;
    sh_d = sh_q;
    push = 1'b0;
    push_data = i_db;
    push_dc = i_data_command_select;
    rd_act = 1'b0;
    case (mode)
      LHB_MODE_SEP: begin
        // rising edge of write strobe takes the byte
        push = sel & i_wr_n_rw & ~wr_q;
        rd_act = sel & ~i_rd_n_en;
      end
      LHB_MODE_ENA: begin
        // falling edge of enable with direction low writes
        push = sel & ~i_rd_n_en & rd_q & ~i_wr_n_rw;
        rd_act = sel & i_rd_n_en & i_wr_n_rw;
      end
      default: begin
        // serial is write only; strobe pins are ignored
        if (!sel) begin
          cnt_d = 4'h0;
        end else if (i_db[`LHB_SER_SCL_BIT] & ~scl_q) begin
          sh_d = {sh_q[DATA_W-2:0], i_db[`LHB_SER_SI_BIT]};
          if (cnt_q == `LHB_SER_BITS - 4'h1) begin
            cnt_d = 4'h0;
            push = 1'b1;
            push_data = {sh_q[DATA_W-2:0], i_db[`LHB_SER_SI_BIT]};
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
    endcase
    // drive only during a read, released when deselected
    rde_d = rd_act;
    db_d = rd_act ? i_rd_data : db_q;
    rdp_d = rde_q & ~rd_act;
  end
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      wr_q <= 1'b1;
      rd_q <= 1'b0;
      scl_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= '0;
      db_q <= '0;
      rde_q <= 1'b0;
      rdp_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      scl_q <= scl_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      db_q <= db_d;
      rde_q <= rde_d;
      rdp_q <= rdp_d;
    end
  end
  assign o_db = db_q;
  assign o_db_oe_n = ~rde_q;
  assign o_rd_pulse = rdp_q;
  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer; a pushed byte with the buffer full is dropped, so
  // hosts must pace writes by o_in_ready (no pin can stall the bus)
  localparam int DEPTH = `LHB_BUF_DEPTH;
  logic [DATA_W:0] mem_q [DEPTH], mem_d [DEPTH]; // entries {dc,byte}
  logic wp_q, wp_d, rp_q, rp_d; // pointers
  logic [1:0] n_q, n_d; // fill level
  logic do_in, do_out; // transfers
  always_comb begin
    do_in = push & (n_q != 2'h2);
    do_out = (n_q != 2'h0) & i_rx_ready;
    wp_d = wp_q ^ do_in;
    rp_d = rp_q ^ do_out;
    n_d = n_q + {1'b0, do_in} - {1'b0, do_out};
    for (int k = 0; k < DEPTH; k++) begin
      mem_d[k] = mem_q[k];
    end
    if (do_in) begin
      mem_d[wp_q] = {push_dc, push_data};
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      n_q <= 2'h0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q <= n_d;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= mem_d[k];
      end
    end
  end
  assign o_rx_valid = (n_q != 2'h0);
  assign o_rx_data = mem_q[rp_q][DATA_W-1:0];
  assign o_rx_is_data = mem_q[rp_q][DATA_W];
  assign o_in_ready = (n_q != 2'h2);
  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_drive_desel;
    @(posedge i_ref_clk) disable iff (rst)
      !sel |=> o_db_oe_n;
  endproperty
  drive_desel_a: assert property (p_no_drive_desel)
    else $error("bus driven while deselected");
  sep_read_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_SEP && sel && !i_rd_n_en) |=> !o_db_oe_n)
    else $error("no drive during read strobe");
  ena_read_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_ENA && sel && i_rd_n_en && i_wr_n_rw)
      |=> !o_db_oe_n)
    else $error("no drive during enable read");
  ser_nodrive_a: assert property (
    @(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_SER) |=> o_db_oe_n)
    else $error("serial mode drove the bus");
  sep_write_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_SEP && sel && i_wr_n_rw && !wr_q && n_q == 2'h0
      && !i_rx_ready) |=> (o_rx_valid && o_rx_data == $past(i_db)))
    else $error("write edge byte not stored");
  ena_write_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_ENA && sel && !i_rd_n_en && rd_q && !i_wr_n_rw
      && n_q == 2'h0) |=> o_rx_valid)
    else $error("enable falling edge not stored");
  dc_tag_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (do_in && n_q == 2'h0) |=> o_rx_is_data == $past(i_data_command_select))
    else $error("command select not kept");
  desel_push_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    !sel |-> !push)
    else $error("byte taken while deselected");
  ser_count_a: assert property (@(posedge i_ref_clk) disable iff (rst)
    (mode == LHB_MODE_SER && push) |-> cnt_q == 4'h7)
    else $error("serial byte not eight bits");
  reset_a: assert property (@(posedge i_ref_clk)
    !i_module_reset_n |=> (!o_rx_valid && o_db_oe_n))
    else $error("reset pin did not reset");
  full_c: cover property (@(posedge i_ref_clk) n_q == 2'h2);
  ser_c: cover property (@(posedge i_ref_clk) mode == LHB_MODE_SER && push);
  rd_c: cover property (@(posedge i_ref_clk) o_rd_pulse);
endmodule
`default_nettype wire

// [lhb_host.sv]
// host bus master model
`timescale 1ns/10ps
`default_nettype none
module lhb_host (
  input wire logic i_clk, // clock
  input wire logic [7:0] i_ddb, // device drive
  input wire logic i_doe_n, // device drives, low
  output logic [13:0] o_pins // select, strobes, bus
);
  logic cs_n = 1'h1, dc = 1'h0, sty = 1'h0, ps = 1'h1, wr = 1'h1, rd = 1'h1;
  logic [7:0] hv = 8'h00; // host drive value
  logic he = 1'h1; // host drives; freed lines invert
  assign o_pins = {cs_n, dc, sty, ps, wr, rd,
    !i_doe_n ? i_ddb : (he ? hv : ~hv)};
  ////////////////////
  // one access, levels held three clocks
  task automatic par(input logic c, p, s, r, a, input logic [7:0] d,
    output logic [7:0] q);
    {cs_n, ps, sty, dc, hv, he} = {c, p, s, a, d, !r};
    {wr, rd} = {r, s | !r};
    repeat (3) @(negedge i_clk);
    q = o_pins[7:0];
    {wr, rd} = {s ? r : 1'h1, !s};
    repeat (3) @(negedge i_clk);
    {cs_n, he} = 2'h3;
    // stay deselected for one clock so a following call never
    // toggles chip select twice in one step
    @(negedge i_clk);
  endtask
  // serial write, msb first, clock still between bytes
  task automatic ser(input logic a, input logic [7:0] d);
    {cs_n, ps, wr, rd, he, hv} = {5'h07, 8'h3f};
    for (int i = 7; i >= 0; i--) begin
      {hv[7:6], dc} = {d[i], 1'h0, a};
      repeat (2) @(negedge i_clk);
      hv[6] = 1'h1;
      repeat (2) @(negedge i_clk);
    end
    cs_n = 1'h1;
    @(negedge i_clk); // one deselected clock between bytes
  endtask
endmodule
`default_nettype wire

// [lhb_host_bus_tb_top.sv]
// bench for the lcd host bus
`timescale 1ns/10ps
`default_nettype none
module lhb_host_bus_tb_top;
  logic clk = 1'h0, rst = 1'h1, mrst_n = 1'h1, rdy = 1'h0, drove = 1'h0;
  logic oe_n, vld, isd, inr, mser, rdp;
  logic [13:0] pins;
  logic [7:0] rdd = 8'h00, d, q, odb, rxd;
  logic [8:0] expq[$], ex; // expected entries, oldest first
  int num_errors = 0, comparisons = 0, cycles = 0, rd_cnt = 0;
  always #50 clk = ~clk; // 10 MHz
  lhb_host host (.i_clk(clk), .i_ddb(odb), .i_doe_n(oe_n), .o_pins(pins));
  lhb_host_bus dut (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_chip_select_n(pins[13]), .i_module_reset_n(mrst_n),
    .i_data_command_select(pins[12]), .i_bus_style_select(pins[11]),
    .i_par_ser_select(pins[10]), .i_wr_n_rw(pins[9]), .i_rd_n_en(pins[8]),
    .i_db(pins[7:0]), .o_db(odb), .o_db_oe_n(oe_n), .o_mode_ser(mser),
    .o_rx_valid(vld), .i_rx_ready(rdy), .o_rx_data(rxd),
    .o_rx_is_data(isd), .i_rd_data(rdd), .o_rd_pulse(rdp),
    .o_in_ready(inr));
  ////////////////////
  task automatic chk(input logic [8:0] g, e); // x matches only x
    comparisons++;
    num_errors += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask
  task automatic chk_rx(input logic [8:0] g, e); // handed-over entry
    chk(g, e);
  endtask
  task automatic chk_rd(input logic [7:0] g, e); // byte read off the bus
    chk({1'h0, g}, {1'h0, e});
  endtask
  task automatic summarize; // counts, verdict, stop
    $display("errors %0d of %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic put(input logic p, s, a); // random byte, random stall
    {d, rdy} = 9'($urandom);
    while (inr !== 1'h1) @(negedge clk) rdy = 1'h1;
    expq.push_back({a, d});
    if (p) host.par(1'h0, 1'h1, s, 1'h0, a, d, q);
    else host.ser(a, d);
  endtask
  always @(posedge clk) begin // oldest note per handed-over byte
    if (!rst && mrst_n && vld === 1'h1 && rdy === 1'h1) begin
      ex = expq.size() != 0 ? expq.pop_front() : ~{isd, rxd};
      chk_rx({isd, rxd}, ex);
    end
    if (oe_n === 1'h0) drove = 1'h1;
    if (rdp === 1'h1) rd_cnt++; // one count per read-end pulse cycle
    chk({8'h00, mser}, {8'h00, ~pins[10]});
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(49));
    repeat (5) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk({7'h00, oe_n, vld}, 9'h002);
    for (int i = 0; i < 8; i++) put(1'h1, i[1], i[0]);
    for (int i = 0; i < 4; i++) put(1'h0, 1'h0, i[0]);
    for (int i = 0; i < 4; i++) begin
      rdd = 8'($urandom);
      host.par(1'h0, 1'h1, i[0], 1'h1, i[1], 8'h00, q);
      chk_rd(q, rdd);
    end
    chk({1'h0, 8'(rd_cnt)}, 9'h004);
    drove = 1'h0;
    host.par(1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 8'h5a, q);
    host.par(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 8'h5a, q);
    host.par(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00, q);
    chk({8'(rd_cnt), drove}, 9'h008);
    rdy = 1'h1; // hand over whatever is still buffered
    @(negedge clk);
    while (expq.size() != 0) @(negedge clk);
    rdy = 1'h0;
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      if (i < 2) expq.push_back({1'h0, d});
      host.par(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, d, q);
    end
    chk({8'h00, inr}, 9'h000);
    rdy = 1'h1; // both kept bytes come out; a stored third would mismatch
    repeat (4) @(negedge clk);
    chk({7'h00, expq.size() == 0, vld}, 9'h002);
    rdy = 1'h0; // leave one byte waiting so the reset has work to do
    host.par(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 8'ha5, q);
    chk({7'h00, oe_n, vld}, 9'h003);
    mrst_n = 1'h0;
    @(negedge clk) mrst_n = 1'h1;
    @(negedge clk);
    chk({7'h00, oe_n, vld}, 9'h002);
    summarize();
  end
endmodule
`default_nettype wire
